// *** logic/wdw_pkg.sv ***
// Shared constants and types for the windowed watchdog control block
package wdw_pkg;
    // Register indices; byte address is four times the index
    localparam logic [5:0] IDX_TIMING_CONTROL = 6'h00;
    localparam logic [5:0] IDX_STATE_FLAGS = 6'h01;
    localparam logic [5:0] IDX_EVENT_FLAGS = 6'h02;
    localparam logic [5:0] IDX_EVENT_MASK = 6'h03;
    localparam logic [5:0] IDX_UNLOCK_KEY = 6'h04;
    localparam logic [5:0] IDX_KICK = 6'h05;

    // Field positions in the state flags register
    localparam int FREEZE_BIT = 7;
    localparam int BUSY_BIT = 0;
    localparam logic [7:0] STATE_FLAGS_RESET = 8'h00;
    localparam logic [7:0] TIMING_CONTROL_RESET = 8'h00;

    // Event bits: time-out, early kick, refused control write
    localparam int EV_TIMEOUT = 0;
    localparam int EV_EARLY = 1;
    localparam int EV_REFUSED = 2;
    localparam int EV_COUNT = 3;
    localparam logic [EV_COUNT-1:0] EVENT_RESET = 3'h0;

    // Unlock key; value is arbitrary
    localparam logic [7:0] UNLOCK_KEY_VALUE = 8'hd8;
    localparam logic [2:0] UNLOCK_WRITES = 3'h4;

    // Slow watchdog clock as an enable pulse
    localparam int SYS_CLK_HZ = 200000000;
    localparam int WDOG_CLK_HZ = 1024;
    localparam int WDOG_DIV_CYCLES = SYS_CLK_HZ / WDOG_CLK_HZ;
    localparam logic [1:0] SYNC_TICKS = 2'h2;

    localparam logic [3:0] CODE_OFF = 4'h0;
    localparam logic [3:0] CODE_MAX = 4'hb;
    localparam int SPAN_SHIFT = 2;
    localparam int SPAN_W = 14;

    typedef struct packed {
        logic [3:0] window;
        logic [3:0] period;
    } wdw_ctrl_t;

    typedef enum {
        ST_OFF,
        ST_NORMAL,
        ST_CLOSED,
        ST_OPEN
    } wdw_state_t;
endpackage

// *** logic/wdw_tick_div.sv ***
// Divider that turns the system clock into a one-cycle slow tick
`timescale 1ns/1ps
`default_nettype none
module wdw_tick_div #(
    parameter int DIV = 4
) (
    input wire logic sys_clk,
    input wire logic srst,
    output logic tick
);
    logic [31:0] cnt_reg;

    always_ff @(posedge sys_clk) begin
        if (srst) begin
            cnt_reg <= 32'h0;
            tick <= 1'b0;
        end else if (cnt_reg == 32'(DIV - 1)) begin
            cnt_reg <= 32'h0;
            tick <= 1'b1;
        end else begin
            cnt_reg <= cnt_reg + 32'h1;
            tick <= 1'b0;
        end
    end
endmodule
`default_nettype wire

// *** logic/wdw_core.sv ***
// Windowed watchdog: control, freeze, crossing flag and counter
`timescale 1ns/1ps
`default_nettype none
// How it works
// - Non-zero upper control nibble selects window mode, closed span 8 to 8K ticks.
// - Non-zero lower nibble enables the watchdog with a doubling time-out.
// - In window mode the lower nibble sets the open span length.
// - With freeze set, both control fields ignore writes; otherwise read-write.
// - Writing one to status bit 7 sets the freeze bit.
// - Freeze accepts only ones, and clears only in debug mode.
// - Non-zero boot time-out field sets freeze automatically.
// - Freeze writes need the unlock sequence first.
// - Status bit 0 rises on an accepted control write and holds during crossing.
// - Hardware alone clears the busy flag when the crossing ends.
// - Busy flag is read-only and needs no unlock.
// - Status register resets to zero.
// - No control write while busy; kicks during kick crossing are ignored.
// - Early kick or missing kick causes system reset; timely kick restarts.
// - Counter advances on a 1.024 kHz tick.
module wdw_core
    import wdw_pkg::*;
#(
    parameter int TICK_DIV = WDOG_DIV_CYCLES
) (
    input wire logic sys_clk,
    input wire logic srst,
    input wire logic wb_cyc_i,
    input wire logic wb_stb_i,
    input wire logic wb_we_i,
    input wire logic [7:0] wb_adr_i,
    input wire logic [3:0] wb_sel_i,
    input wire logic [31:0] wb_dat_i,
    output logic [31:0] wb_dat_o,
    output logic wb_ack_o,
    input wire logic [7:0] bootConfigFuse,
    input wire logic debugMode,
    output logic sysResetReq,
    output logic irq
);
    wdw_ctrl_t timingControl_reg;
    wdw_ctrl_t activeCtrl_reg;
    wdw_state_t state_reg;
    logic freeze_reg;
    logic busy_reg;
    logic bootDone_reg;
    logic [1:0] syncCnt_reg;
    logic kickPending_reg;
    logic [1:0] kickCnt_reg;
    logic [2:0] guardCnt_reg;
    logic [SPAN_W-1:0] count_reg;
    logic [EV_COUNT-1:0] events_reg;
    logic [EV_COUNT-1:0] mask_reg;
    logic slowTick;
    logic busWrite;
    logic [5:0] regIdx;
    logic unlocked;
    logic ctrlWrite;
    logic ctrlAccepted;
    logic freezeWrite;
    logic kickApply;
    logic earlyKick;
    logic timeout;
    logic [EV_COUNT-1:0] evSet;
    logic [SPAN_W-1:0] closedSpan;
    logic [SPAN_W-1:0] openSpan;
    logic [3:0] bootConfigFuse_q;

    wdw_tick_div #(.DIV(TICK_DIV)) tickDiv (
        .sys_clk(sys_clk),
        .srst(srst),
        .tick(slowTick)
    );

    function automatic logic [SPAN_W-1:0] spanOf(input logic [3:0] code);
        logic [3:0] c;
        c = (code > CODE_MAX) ? CODE_MAX : code;
        spanOf = SPAN_W'(1) << (c + 4'(SPAN_SHIFT));
    endfunction

    assign busWrite = wb_cyc_i && wb_stb_i && wb_we_i && !wb_ack_o && wb_sel_i[0];
    assign regIdx = wb_adr_i[7:2];
    assign unlocked = guardCnt_reg != 3'h0;
    assign ctrlWrite = busWrite && regIdx == IDX_TIMING_CONTROL;
    // Writes while busy are dropped, so a crossing is never corrupted
    assign ctrlAccepted = ctrlWrite && unlocked && !freeze_reg && !busy_reg;
    assign freezeWrite = busWrite && regIdx == IDX_STATE_FLAGS && unlocked;
    assign closedSpan = spanOf(activeCtrl_reg.window);
    assign openSpan = spanOf(activeCtrl_reg.period);

    // Unlock guard: key opens a window of four following writes
    always_ff @(posedge sys_clk) begin
        if (srst) begin
            guardCnt_reg <= 3'h0;
        end else if (busWrite && regIdx == IDX_UNLOCK_KEY) begin
            guardCnt_reg <= (wb_dat_i[7:0] == UNLOCK_KEY_VALUE) ? UNLOCK_WRITES : 3'h0;
        end else if (busWrite && unlocked) begin
            guardCnt_reg <= guardCnt_reg - 3'h1;
        end
    end

    // Control register, loaded from the fuse once after reset
    always_ff @(posedge sys_clk) begin
        if (srst) begin
            timingControl_reg <= TIMING_CONTROL_RESET;
            bootDone_reg <= 1'b0;
        end else if (!bootDone_reg) begin
            timingControl_reg <= bootConfigFuse;
            bootDone_reg <= 1'b1;
        end else if (ctrlAccepted) begin
            timingControl_reg <= wb_dat_i[7:0];
        end
    end

    // Freeze bit
    always_ff @(posedge sys_clk) begin
        if (srst) begin
            freeze_reg <= STATE_FLAGS_RESET[FREEZE_BIT];
        end else if (!bootDone_reg) begin
            freeze_reg <= bootConfigFuse[3:0] != CODE_OFF;
        end else if (freezeWrite && wb_dat_i[FREEZE_BIT]) begin
            freeze_reg <= 1'b1;
        end else if (freezeWrite && debugMode) begin
            freeze_reg <= 1'b0;
        end
    end

    // Crossing into the slow domain takes SYNC_TICKS ticks
    always_ff @(posedge sys_clk) begin
        if (srst) begin
            busy_reg <= STATE_FLAGS_RESET[BUSY_BIT];
            syncCnt_reg <= 2'h0;
            activeCtrl_reg <= TIMING_CONTROL_RESET;
        end else if (!bootDone_reg) begin
            activeCtrl_reg <= bootConfigFuse;
        end else if (ctrlAccepted) begin
            busy_reg <= 1'b1;
            syncCnt_reg <= 2'h0;
        end else if (busy_reg && slowTick) begin
            if (syncCnt_reg == SYNC_TICKS - 2'h1) begin
                busy_reg <= 1'b0;
                activeCtrl_reg <= timingControl_reg;
            end else begin
                syncCnt_reg <= syncCnt_reg + 2'h1;
            end
        end
    end

    // Kick crossing; a second kick meanwhile is dropped
    always_ff @(posedge sys_clk) begin
        if (srst) begin
            kickPending_reg <= 1'b0;
            kickCnt_reg <= 2'h0;
        end else if (busWrite && regIdx == IDX_KICK && !kickPending_reg) begin
            kickPending_reg <= 1'b1;
            kickCnt_reg <= 2'h0;
        end else if (kickPending_reg && slowTick) begin
            if (kickCnt_reg == SYNC_TICKS - 2'h1) begin
                kickPending_reg <= 1'b0;
            end else begin
                kickCnt_reg <= kickCnt_reg + 2'h1;
            end
        end
    end

    assign kickApply = kickPending_reg && slowTick && kickCnt_reg == SYNC_TICKS - 2'h1;
    assign earlyKick = kickApply && state_reg == ST_CLOSED;
    assign timeout = slowTick && !kickApply && !debugMode && count_reg == SPAN_W'(0)
        && (state_reg == ST_NORMAL || state_reg == ST_OPEN);

    // Counter and window sequencing on the slow tick
    always_ff @(posedge sys_clk) begin
        if (srst) begin
            state_reg <= ST_OFF;
            count_reg <= '0;
        end else if (activeCtrl_reg.period == CODE_OFF) begin
            state_reg <= ST_OFF;
            count_reg <= '0;
        end else if (debugMode) begin
            // Halted CPU: counter reset, first closed span skipped on resume
            state_reg <= ST_NORMAL;
            count_reg <= openSpan - SPAN_W'(1);
        end else begin
            case (state_reg)
                ST_OFF: begin
                    state_reg <= ST_NORMAL;
                    count_reg <= openSpan - SPAN_W'(1);
                end
                ST_NORMAL, ST_OPEN: begin
                    if (kickApply && activeCtrl_reg.window != CODE_OFF) begin
                        state_reg <= ST_CLOSED;
                        count_reg <= closedSpan - SPAN_W'(1);
                    end else if (kickApply || timeout) begin
                        state_reg <= ST_NORMAL;
                        count_reg <= openSpan - SPAN_W'(1);
                    end else if (slowTick) begin
                        count_reg <= count_reg - SPAN_W'(1);
                    end
                end
                ST_CLOSED: begin
                    if (earlyKick) begin
                        state_reg <= ST_NORMAL;
                        count_reg <= openSpan - SPAN_W'(1);
                    end else if (slowTick && count_reg == SPAN_W'(0)) begin
                        state_reg <= ST_OPEN;
                        count_reg <= openSpan - SPAN_W'(1);
                    end else if (slowTick) begin
                        count_reg <= count_reg - SPAN_W'(1);
                    end
                end
                default: begin
                    state_reg <= ST_OFF;
                end
            endcase
        end
    end

    always_ff @(posedge sys_clk) begin
        if (srst) begin
            sysResetReq <= 1'b0;
        end else begin
            sysResetReq <= earlyKick || timeout;
        end
    end

    // Events: set wins over a write-one clear
    assign evSet[EV_TIMEOUT] = timeout;
    assign evSet[EV_EARLY] = earlyKick;
    assign evSet[EV_REFUSED] = ctrlWrite && !ctrlAccepted;

    always_ff @(posedge sys_clk) begin
        if (srst) begin
            events_reg <= EVENT_RESET;
            mask_reg <= EVENT_RESET;
        end else begin
            if (busWrite && regIdx == IDX_EVENT_FLAGS) begin
                events_reg <= (events_reg & ~wb_dat_i[EV_COUNT-1:0]) | evSet;
            end else begin
                events_reg <= events_reg | evSet;
            end
            if (busWrite && regIdx == IDX_EVENT_MASK) begin
                mask_reg <= wb_dat_i[EV_COUNT-1:0];
            end
        end
    end

    always_ff @(posedge sys_clk) begin
        if (srst) begin
            irq <= 1'b0;
        end else begin
            irq <= |(events_reg & mask_reg);
        end
    end

    // Wishbone slave: one wait state, unmapped reads return zero
    always_ff @(posedge sys_clk) begin
        if (srst) begin
            wb_ack_o <= 1'b0;
            wb_dat_o <= 32'h0;
        end else begin
            wb_ack_o <= wb_cyc_i && wb_stb_i && !wb_ack_o;
            case (regIdx)
                IDX_TIMING_CONTROL: wb_dat_o <= {24'h0, timingControl_reg};
                IDX_STATE_FLAGS: wb_dat_o <= {24'h0, freeze_reg, 6'h0, busy_reg};
                IDX_EVENT_FLAGS: wb_dat_o <= {29'h0, events_reg};
                IDX_EVENT_MASK: wb_dat_o <= {29'h0, mask_reg};
                default: wb_dat_o <= 32'h0;
            endcase
        end
    end

    sequence ctrlWriteSeq;
        ctrlAccepted;
    endsequence

    property busyHeld;
        @(posedge sys_clk) disable iff (srst)
        ctrlWriteSeq |=> busy_reg [*2];
    endproperty

    busy_set_a: assert property (busyHeld) else $error("busy not set after write");
    freeze_hold_a: assert property (@(posedge sys_clk) disable iff (srst)
        bootDone_reg && $past(bootDone_reg) && $fell(freeze_reg) |-> $past(debugMode))
        else $error("freeze cleared outside debug");
    ctrl_frozen_a: assert property (@(posedge sys_clk) disable iff (srst)
        bootDone_reg && freeze_reg |=> $stable(timingControl_reg))
        else $error("control changed while frozen");
    boot_freeze_a: assert property (@(posedge sys_clk) disable iff (srst)
        !srst && !bootDone_reg |=> freeze_reg == (bootConfigFuse_q != CODE_OFF))
        else $error("boot freeze wrong");
    busy_clear_a: assert property (@(posedge sys_clk) disable iff (srst)
        $fell(busy_reg) |-> $past(slowTick) && activeCtrl_reg == timingControl_reg)
        else $error("busy cleared early");
    guard_need_a: assert property (@(posedge sys_clk) disable iff (srst)
        bootDone_reg && $past(bootDone_reg) && $rose(freeze_reg) |-> $past(unlocked))
        else $error("freeze set without unlock");
    early_reset_a: assert property (@(posedge sys_clk) disable iff (srst)
        earlyKick |=> sysResetReq ##1 state_reg == ST_NORMAL)
        else $error("early kick did not reset");
    status_reset_a: assert property (@(posedge sys_clk)
        srst |=> !busy_reg && !freeze_reg)
        else $error("status not zero after reset");

    // A kick raised while one is still crossing must not restart it
    sequence kickAgainSeq;
        kickPending_reg && !kickApply && busWrite && regIdx == IDX_KICK;
    endsequence

    sequence windowKickSeq;
        kickApply && !debugMode && activeCtrl_reg.period != CODE_OFF
            && activeCtrl_reg.window != CODE_OFF
            && (state_reg == ST_NORMAL || state_reg == ST_OPEN);
    endsequence

    sequence closedEndSeq;
        state_reg == ST_CLOSED && slowTick && count_reg == SPAN_W'(0) && !kickApply
            && !debugMode && activeCtrl_reg.period != CODE_OFF;
    endsequence

    kick_drop_a: assert property (@(posedge sys_clk) disable iff (srst)
        kickAgainSeq |=> kickPending_reg && kickCnt_reg == $past(kickCnt_reg) + 2'($past(slowTick)))
        else $error("second kick restarted crossing");
    win_close_a: assert property (@(posedge sys_clk) disable iff (srst)
        windowKickSeq |=> state_reg == ST_CLOSED && count_reg == $past(closedSpan) - SPAN_W'(1))
        else $error("kick did not open closed span");
    open_span_a: assert property (@(posedge sys_clk) disable iff (srst)
        closedEndSeq |=> state_reg == ST_OPEN)
        else $error("open span did not follow closed span");
    timeout_rst_a: assert property (@(posedge sys_clk) disable iff (srst)
        timeout && activeCtrl_reg.period != CODE_OFF |=> sysResetReq && state_reg == ST_NORMAL)
        else $error("time-out did not reset");
    wdog_off_a: assert property (@(posedge sys_clk) disable iff (srst)
        activeCtrl_reg.period == CODE_OFF |=> state_reg == ST_OFF)
        else $error("watchdog ran with zero period");
    refused_ev_a: assert property (@(posedge sys_clk) disable iff (srst)
        ctrlWrite && freeze_reg |=> events_reg[EV_REFUSED])
        else $error("refused write not flagged");
    flag_write_a: assert property (@(posedge sys_clk) disable iff (srst)
        busWrite && regIdx == IDX_STATE_FLAGS && !busy_reg |=> !busy_reg)
        else $error("flags write touched busy");
    key_open_a: assert property (@(posedge sys_clk) disable iff (srst)
        busWrite && regIdx == IDX_UNLOCK_KEY && wb_dat_i[7:0] == UNLOCK_KEY_VALUE
        |=> guardCnt_reg == UNLOCK_WRITES)
        else $error("key did not open guard");

    always_ff @(posedge sys_clk) begin
        bootConfigFuse_q <= bootConfigFuse[3:0];
    end
endmodule
`default_nettype wire

// *** verification/wdw_core_tb.sv ***
// Self-checking bench for the windowed watchdog control block
`timescale 1ns/1ps
`default_nettype none
module wdw_core_tb
    import wdw_pkg::*;
;
    // Short slow tick keeps every span a few dozen system cycles
    localparam int TICKS = 4;
    logic sysClk = 1'b0;
    logic srst = 1'b1;
    logic wbCyc = 1'b0;
    logic wbStb = 1'b0;
    logic wbWe = 1'b0;
    logic [7:0] wbAdr = 8'h00;
    logic [3:0] wbSel = 4'h0;
    logic [31:0] wbDatI = 32'h0000_0000;
    logic [31:0] wbDatO;
    logic wbAck;
    logic [7:0] bootConfigFuse = 8'h00;
    logic debugMode = 1'b0;
    logic sysResetReq;
    logic irq;
    logic [31:0] rdData;
    int badCount = 0;
    int nChecks = 0;

    always #2.5 sysClk = ~sysClk;

    wdw_core #(.TICK_DIV(TICKS)) wdw_core_inst (
        .sys_clk(sysClk),
        .srst(srst),
        .wb_cyc_i(wbCyc),
        .wb_stb_i(wbStb),
        .wb_we_i(wbWe),
        .wb_adr_i(wbAdr),
        .wb_sel_i(wbSel),
        .wb_dat_i(wbDatI),
        .wb_dat_o(wbDatO),
        .wb_ack_o(wbAck),
        .bootConfigFuse(bootConfigFuse),
        .debugMode(debugMode),
        .sysResetReq(sysResetReq),
        .irq(irq)
    );

    task automatic results;
        $display("checks %0d mismatches %0d", nChecks, badCount);
        if (badCount == 0 && nChecks > 0) begin
            $display("ALL TESTS PASSED");
        end else begin
            $display("TESTS FAILED");
        end
        $finish;
    endtask

    task automatic chk(input string what, input logic [31:0] exp, input logic [31:0] got);
        nChecks++;
        if (got !== exp) begin
            badCount++;
            $display("wrong value %s expected %h seen %h", what, exp, got);
        end
    endtask

    // Request held until ack is sampled high, released only after that edge
    task automatic bus(input logic wr, input logic [5:0] idx, input logic [7:0] d,
                       output logic [31:0] q);
        int n;
        n = 0;
        @(posedge sysClk);
        wbCyc <= 1'b1;
        wbStb <= 1'b1;
        wbWe <= wr;
        wbSel <= 4'hf;
        wbAdr <= {idx, 2'b00};
        wbDatI <= {24'h000000, d};
        do begin
            @(posedge sysClk);
            n++;
        end while (wbAck !== 1'b1 && n < 20);
        q = wbDatO;
        wbCyc <= 1'b0;
        wbStb <= 1'b0;
        wbWe <= 1'b0;
        if (wbAck !== 1'b1) begin
            chk("bus ack", 32'h1, 32'h0);
            results();
        end
    endtask

    task automatic wr(input logic [5:0] idx, input logic [7:0] d);
        bus(1'b1, idx, d, rdData);
    endtask

    task automatic rdChk(input logic [5:0] idx, input logic [31:0] exp, input string what);
        bus(1'b0, idx, 8'h00, rdData);
        chk(what, exp, rdData);
    endtask

    task automatic unlock;
        wr(IDX_UNLOCK_KEY, UNLOCK_KEY_VALUE);
    endtask

    task automatic waitBusy;
        int n;
        n = 0;
        do begin
            bus(1'b0, IDX_STATE_FLAGS, 8'h00, rdData);
            n++;
        end while (rdData[BUSY_BIT] !== 1'b0 && n < 30);
        chk("busy cleared", 32'h0, {31'h0, rdData[BUSY_BIT]});
        if (rdData[BUSY_BIT] !== 1'b0) begin
            results();
        end
    endtask

    task automatic waitRst(input int bound);
        int n;
        n = 0;
        do begin
            @(posedge sysClk);
            n++;
        end while (sysResetReq !== 1'b1 && n < bound);
        chk("system reset pulse", 32'h1, {31'h0, sysResetReq});
        if (sysResetReq !== 1'b1) begin
            results();
        end
    endtask

    task automatic doReset;
        srst <= 1'b1;
        repeat (16) @(posedge sysClk);
        srst <= 1'b0;
    endtask

    initial begin
        doReset();
        rdChk(IDX_TIMING_CONTROL, 32'h0, "control after reset");
        rdChk(IDX_STATE_FLAGS, {24'h0, STATE_FLAGS_RESET}, "flags after reset");
        rdChk(IDX_EVENT_FLAGS, 32'h0, "events after reset");
        rdChk(6'h3f, 32'h0, "unmapped read");
        $display("test reset values done");
        // Locked-out control write raises the refused event
        wr(IDX_TIMING_CONTROL, 8'h23);
        rdChk(IDX_TIMING_CONTROL, 32'h0, "control without unlock");
        wr(IDX_EVENT_MASK, 8'h04);
        repeat (3) @(posedge sysClk);
        chk("irq on refused write", 32'h1, {31'h0, irq});
        wr(IDX_EVENT_FLAGS, 8'h04);
        repeat (3) @(posedge sysClk);
        chk("irq after clear", 32'h0, {31'h0, irq});
        rdChk(IDX_EVENT_FLAGS, 32'h0, "events after clear");
        $display("test refusal and interrupt done");
        unlock();
        wr(IDX_TIMING_CONTROL, 8'h01);
        rdChk(IDX_STATE_FLAGS, 32'h01, "busy after control write");
        waitBusy();
        rdChk(IDX_TIMING_CONTROL, 32'h01, "control after unlock");
        waitRst(300);
        rdChk(IDX_EVENT_FLAGS, 32'h01, "time-out event");
        $display("test normal time-out done");
        wr(IDX_EVENT_FLAGS, 8'h07);
        unlock();
        wr(IDX_TIMING_CONTROL, 8'h11);
        waitBusy();
        wr(IDX_KICK, 8'h00);
        wr(IDX_KICK, 8'h00);
        repeat (16) @(posedge sysClk);
        wr(IDX_KICK, 8'h00);
        waitRst(100);
        bus(1'b0, IDX_EVENT_FLAGS, 8'h00, rdData);
        chk("early kick event", 32'h2, rdData & 32'h2);
        $display("test window early kick done");
        // Kick after the closed span has run out is timely
        wr(IDX_EVENT_FLAGS, 8'h07);
        wr(IDX_KICK, 8'h00);
        repeat (48) @(posedge sysClk);
        wr(IDX_KICK, 8'h00);
        repeat (16) @(posedge sysClk);
        rdChk(IDX_EVENT_FLAGS, 32'h0, "kick in open span");
        $display("test window timely kick done");
        // Wrong key closes any guard left open by earlier writes
        wr(IDX_UNLOCK_KEY, 8'h00);
        wr(IDX_STATE_FLAGS, 8'h80);
        rdChk(IDX_STATE_FLAGS, 32'h00, "freeze without unlock");
        unlock();
        wr(IDX_STATE_FLAGS, 8'h80);
        rdChk(IDX_STATE_FLAGS, 32'h80, "freeze set");
        unlock();
        wr(IDX_TIMING_CONTROL, 8'h45);
        rdChk(IDX_TIMING_CONTROL, 32'h11, "control while frozen");
        bus(1'b0, IDX_EVENT_FLAGS, 8'h00, rdData);
        chk("refused event while frozen", 32'h4, rdData & 32'h4);
        unlock();
        wr(IDX_STATE_FLAGS, 8'h00);
        rdChk(IDX_STATE_FLAGS, 32'h80, "freeze clear outside debug");
        debugMode <= 1'b1;
        unlock();
        wr(IDX_STATE_FLAGS, 8'h00);
        rdChk(IDX_STATE_FLAGS, 32'h00, "freeze clear in debug");
        debugMode <= 1'b0;
        unlock();
        wr(IDX_TIMING_CONTROL, 8'h00);
        waitBusy();
        rdChk(IDX_TIMING_CONTROL, 32'h00, "control after unfreeze");
        $display("test freeze done");
        bootConfigFuse <= 8'h03;
        doReset();
        rdChk(IDX_TIMING_CONTROL, 32'h03, "control from fuse");
        bus(1'b0, IDX_STATE_FLAGS, 8'h00, rdData);
        chk("boot freeze", 32'h80, rdData & 32'h80);
        $display("test boot freeze done");
        results();
    end
endmodule
`default_nettype wire
